// >>> logic/vr_seq_params.svh
// Timing, reset and encoding constants for the regulator start-up and fault sequencer
`ifndef VR_SEQ_PARAMS_SVH
`define VR_SEQ_PARAMS_SVH
`define CLK_FREQ_HZ 20000000
`define OC_DELAY_US 50
// Longest delay rounds down: 50 us at 20 MHz is 1000 cycles
`define OC_DELAY_CYC ((`OC_DELAY_US * `CLK_FREQ_HZ) / 1000000)
`define DAC_WIDTH 8
`define RAMP_DIV_DEFAULT 16
`define DAC_RESET 8'h00
`define PWM_MID_CODE 2'h2
`define PWM_FLOAT_CODE 2'h0
`define PWM_LOW_CODE 2'h1
`define PWM_RUN_CODE 2'h3
`endif

// >>> logic/vr_seq_pkg.sv
// Types shared by the sequencer files
package vr_seq_pkg;
	typedef enum logic [2:0] {
		st_config,
		st_wait_enable,
		st_mid,
		st_ramp,
		st_run,
		st_oc_latched,
		st_ov_latched
	} seq_state_t;
	typedef logic [1:0] pwm_mode_t;
endpackage

// >>> logic/comp_sync.sv
// Input register stage for the analog comparator results
`timescale 1ns/1ps
module comp_sync #(
	parameter int WIDTH = 6
) (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [WIDTH-1:0] raw, // Comparator outputs
	output logic [WIDTH-1:0] sampled // Registered copy
);
	if (WIDTH < 1) begin : g_bad_width
		$error("comp_sync: WIDTH must be at least 1");
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sampled <= '0;
		end else begin
			sampled <= raw;
		end
	end
endmodule

// >>> logic/vr_softstart_fault_sequencer.sv
// Start-up, soft-start ramp and fault latch sequencer of a step-down regulator controller
// Notes on behaviour
// R1 - While a voltage rise is in progress, pulse negative sense once per DAC increment.
// R2 - Single-phase rail current limit latches that rail off at once, no delay.
// R3 - A driver with low supply pulls driver-on low, blocking controller enable.
// R4 - Driver keeps driver-on low for a hold-off after its undervoltage event.
// R5 - Restart after driver hold-off puts PWM at mid level before soft start.
// R6 - Soft start steps DAC from zero to target at the slow ramp rate.
// R7 - At power-up PWM floats with test current to read address and boot voltage.
// R8 - After configuration and enable, internal and external PWM go to mid level.
// R9 - Driver-on is asserted only after PWM outputs reached mid level.
// R10 - Each phase leaves mid level only at its first PWM pulse during ramp.
// R11 - A disabled controller returns its PWM output to mid level.
// R12 - Two-phase over limit starts a counter; shut down if still present at 50 us.
// R13 - Two-phase current at 150 percent of limit shuts down at once.
// R14 - After overcurrent shutdown outputs stay off until supply or enable toggles.
// R15 - Output more than 300 mV under DAC minus droop drives ready low.
// R16 - In normal operation output 400 mV over DAC drops ready, ramps to 0 V.
// R17 - Overvoltage turns all high-side drives off and all low-side drives on.
// R18 - Overvoltage protective state holds until supply or enable toggles.
// R19 - During start-up the overvoltage threshold is a fixed 2.0 V level.
// R20 - Comparator results are registered on the clock before the state machine.
`timescale 1ns/1ps
`include "vr_seq_params.svh"
module vr_softstart_fault_sequencer
	import vr_seq_pkg::*;
#(
	parameter int DAC_W = `DAC_WIDTH,
	parameter int RAMP_DIV = `RAMP_DIV_DEFAULT,
	parameter int OC_DELAY = `OC_DELAY_CYC
) (
	input wire logic ref_clk, // 20 MHz clock
	input wire logic rst_n, // Async reset, active low; also supply power-on
	input wire logic enable_in, // Controller enable pin
	input wire logic config_done, // Address and boot voltage have been read
	input wire logic [DAC_W-1:0] target_code, // Target DAC code
	input wire logic dynamic_voltage_change, // Voltage rise command, level
	input wire logic driver_on_in, // Driver-on wire level as seen by gates
	input wire logic [1:0] pwm_pulse, // First PWM pulse request per two-phase phase
	input wire logic sp_pwm_pulse, // First PWM pulse of single-phase rail
	input wire logic cmp_uv, // Output below DAC minus droop by 300 mV
	input wire logic cmp_ov_dac, // Output above DAC by 400 mV
	input wire logic cmp_ov_fixed, // Output above fixed 2.0 V
	input wire logic cmp_oc, // Two-phase current over limit
	input wire logic cmp_oc150, // Two-phase current at 150 percent of limit
	input wire logic cmp_sp_current_limit_input, // Single-phase current_limit_input over threshold
	output logic [DAC_W-1:0] dac_code, // Internal DAC code
	output logic [1:0] pwm_mode_a, // Phase 1 PWM mode
	output logic [1:0] pwm_mode_b, // Phase 2 PWM mode
	output logic [1:0] sp_pwm_mode, // Single-phase PWM mode
	output logic test_current_on, // Test current on the PWM pin
	output logic driver_on_out, // Driver-on drive request
	output logic sense_pulse, // Current pulse on negative_sense_input
	output logic regulator_ready, // Ready flag
	output logic hs_off_all, // All high-side drives forced off
	output logic ls_on_all, // All low-side drives forced on
	output logic sp_latched // Single-phase rail latched off
);
	localparam int OC_W = $clog2(OC_DELAY + 1);
	localparam int DIV_W = $clog2(RAMP_DIV + 1);

	// Elaboration-time refusal of sizes the counters cannot serve
	if (DAC_W < 2 || RAMP_DIV < 1 || OC_DELAY < 1) begin : g_bad_params
		$error("vr_softstart_fault_sequencer: bad parameter values");
	end

	typedef struct packed {
		seq_state_t st;
		logic [DAC_W-1:0] dac;
		logic [DIV_W-1:0] div;
		logic [OC_W-1:0] oc_cnt;
		logic [1:0] mode_a;
		logic [1:0] mode_b;
		logic [1:0] sp_mode;
		logic test_cur;
		logic drv_on;
		logic pulse;
		logic ready;
		logic hs_off;
		logic ls_on;
		logic sp_lat;
		logic en_d;
	} seq_reg_t;

	seq_reg_t cur;
	seq_reg_t next_cur;
	logic [5:0] cmp_q;
	logic uv_q, ov_dac_q, ov_fix_q, oc_q, oc150_q, current_limit_input_q;
	logic en_fall, ramp_tick, ov_hit;

	// ---------------------------------------------------------------
	// Comparator capture
	// ---------------------------------------------------------------
	comp_sync #(.WIDTH(6)) u_sync ( // [R20]
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.raw({cmp_uv, cmp_ov_dac, cmp_ov_fixed, cmp_oc, cmp_oc150, cmp_sp_current_limit_input}),
		.sampled(cmp_q)
	);
	assign {uv_q, ov_dac_q, ov_fix_q, oc_q, oc150_q, current_limit_input_q} = cmp_q;

	function automatic logic [1:0] leave_mid(input logic [1:0] mode, input logic pulse);
		leave_mid = (mode == `PWM_MID_CODE && pulse) ? `PWM_RUN_CODE : mode;
	endfunction

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		en_fall = cur.en_d && !enable_in;
		ramp_tick = 1'b0;
		ov_hit = 1'b0;
		next_cur.en_d = enable_in;
		next_cur.pulse = 1'b0;
		// Start-up uses the fixed level so a pre-charged output is not mistaken for a fault
		if (cur.st == st_mid || cur.st == st_ramp) begin
			ov_hit = ov_fix_q; // [R19]
		end else if (cur.st == st_run) begin
			ov_hit = ov_dac_q; // [R16]
		end
		if (cur.div >= DIV_W'(RAMP_DIV - 1)) begin
			next_cur.div = '0;
			ramp_tick = 1'b1;
		end else begin
			next_cur.div = cur.div + 1'b1;
		end
		case (cur.st)
			st_config: begin
				next_cur.mode_a = `PWM_FLOAT_CODE; // [R7]
				next_cur.mode_b = `PWM_FLOAT_CODE;
				next_cur.sp_mode = `PWM_FLOAT_CODE;
				next_cur.test_cur = 1'b1;
				if (config_done) begin
					next_cur.test_cur = 1'b0;
					next_cur.mode_a = `PWM_MID_CODE;
					next_cur.mode_b = `PWM_MID_CODE;
					next_cur.sp_mode = `PWM_MID_CODE;
					next_cur.st = st_wait_enable;
				end
			end
			st_wait_enable: begin
				// Any restart, also after a driver hold-off, begins from mid level
				next_cur.mode_a = `PWM_MID_CODE; // [R5] [R11]
				next_cur.mode_b = `PWM_MID_CODE;
				next_cur.sp_mode = `PWM_MID_CODE;
				next_cur.dac = DAC_W'(`DAC_RESET);
				next_cur.drv_on = 1'b0;
				if (enable_in) begin
					next_cur.st = st_mid; // [R8]
				end
			end
			st_mid: begin
				next_cur.drv_on = 1'b1; // [R9]
				next_cur.div = '0;
				next_cur.st = st_ramp;
			end
			st_ramp, st_run: begin
				next_cur.mode_a = leave_mid(cur.mode_a, pwm_pulse[0]); // [R10]
				next_cur.mode_b = leave_mid(cur.mode_b, pwm_pulse[1]);
				if (!cur.sp_lat) begin
					next_cur.sp_mode = leave_mid(cur.sp_mode, sp_pwm_pulse);
				end
				// Ramp pauses while a driver still holds the driver-on wire low [R3]
				if (ramp_tick && cur.dac < target_code &&
					(cur.st == st_run || driver_on_in)) begin
					next_cur.dac = cur.dac + 1'b1; // [R6]
					if (cur.st == st_ramp || dynamic_voltage_change) begin
						next_cur.pulse = dynamic_voltage_change; // [R1]
					end
				end else if (ramp_tick && cur.st == st_run && cur.dac > target_code) begin
					next_cur.dac = cur.dac - 1'b1;
				end
				if (cur.st == st_ramp && cur.dac >= target_code) begin
					next_cur.st = st_run;
					next_cur.ready = 1'b1;
				end
				if (cur.st == st_run) begin
					next_cur.ready = !uv_q; // [R15]
				end
				if (current_limit_input_q && !cur.sp_lat) begin
					next_cur.sp_lat = 1'b1; // [R2]
					next_cur.sp_mode = `PWM_LOW_CODE;
				end
				if (oc_q) begin
					next_cur.oc_cnt = cur.oc_cnt + 1'b1; // [R12]
				end else begin
					next_cur.oc_cnt = '0;
				end
				if (oc150_q || (oc_q && cur.oc_cnt >= OC_W'(OC_DELAY - 1))) begin
					next_cur.st = st_oc_latched; // [R13] [R12]
					next_cur.ready = 1'b0;
					next_cur.drv_on = 1'b0;
					next_cur.mode_a = `PWM_LOW_CODE;
					next_cur.mode_b = `PWM_LOW_CODE;
					next_cur.sp_mode = `PWM_LOW_CODE;
				end
				if (ov_hit) begin
					next_cur.st = st_ov_latched;
					next_cur.ready = 1'b0;
					next_cur.hs_off = 1'b1; // [R17]
					next_cur.ls_on = 1'b1;
				end
				if (!enable_in) begin
					next_cur.st = st_wait_enable; // [R11]
					next_cur.ready = 1'b0;
					next_cur.drv_on = 1'b0;
					next_cur.mode_a = `PWM_MID_CODE;
					next_cur.mode_b = `PWM_MID_CODE;
					next_cur.sp_mode = `PWM_MID_CODE;
				end
			end
			st_oc_latched: begin
				next_cur.ready = 1'b0; // [R14]
				if (en_fall) begin
					next_cur.st = st_wait_enable;
					next_cur.sp_lat = 1'b0;
					next_cur.oc_cnt = '0;
				end
			end
			st_ov_latched: begin
				// Output ramps down to zero while low sides hold it [R16]
				if (ramp_tick && cur.dac != '0) begin
					next_cur.dac = cur.dac - 1'b1;
				end
				if (en_fall) begin
					next_cur.st = st_wait_enable; // [R18]
					next_cur.hs_off = 1'b0;
					next_cur.ls_on = 1'b0;
					next_cur.drv_on = 1'b0;
					next_cur.sp_lat = 1'b0;
				end
			end
			default: begin
				next_cur.st = st_config;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '{st: st_config, dac: '0, div: '0, oc_cnt: '0, mode_a: `PWM_FLOAT_CODE,
				mode_b: `PWM_FLOAT_CODE, sp_mode: `PWM_FLOAT_CODE, test_cur: 1'b1,
				drv_on: 1'b0, pulse: 1'b0, ready: 1'b0, hs_off: 1'b0, ls_on: 1'b0,
				sp_lat: 1'b0, en_d: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign dac_code = cur.dac;
	assign pwm_mode_a = cur.mode_a;
	assign pwm_mode_b = cur.mode_b;
	assign sp_pwm_mode = cur.sp_mode;
	assign test_current_on = cur.test_cur;
	assign driver_on_out = cur.drv_on;
	assign sense_pulse = cur.pulse;
	assign regulator_ready = cur.ready;
	assign hs_off_all = cur.hs_off;
	assign ls_on_all = cur.ls_on;
	assign sp_latched = cur.sp_lat;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_oc150_fast: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
		(cur.st == st_run && oc150_q && enable_in && !ov_hit) |=> cur.st == st_oc_latched)
		else $error("150 percent current did not shut down at once");
	a_oc_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
		(cur.st == st_oc_latched && !en_fall) |=> cur.st == st_oc_latched && !cur.ready)
		else $error("overcurrent latch released without enable toggle");
	a_ov_drives: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
		cur.st == st_ov_latched |-> cur.hs_off && cur.ls_on && !cur.ready)
		else $error("overvoltage drive state wrong");
	a_ov_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
		(cur.st == st_ov_latched && !en_fall) |=> cur.st == st_ov_latched)
		else $error("overvoltage state left without enable toggle");
	a_drv_after_mid: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
		$rose(cur.drv_on) |-> $past(cur.mode_a) == `PWM_MID_CODE && $past(cur.st) == st_mid)
		else $error("driver-on asserted before mid level");
	a_sp_latch: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
		(cur.st == st_run && current_limit_input_q && enable_in) |=> cur.sp_lat)
		else $error("single-phase rail did not latch off at once");
	a_pulse_inc: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
		cur.pulse |-> cur.dac == $past(cur.dac) + 1'b1)
		else $error("sense pulse without DAC increment");
	a_disable_mid: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
		((cur.st == st_run || cur.st == st_ramp) && !enable_in) |=>
		cur.mode_a == `PWM_MID_CODE && cur.st == st_wait_enable)
		else $error("disabled controller not at mid level");
	a_uv_ready: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
		(cur.st == st_run && uv_q) |=> !cur.ready)
		else $error("ready stayed high under undervoltage");
	a_startup_ov: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
		(cur.st == st_ramp && ov_dac_q && !ov_fix_q && enable_in && !oc150_q && !oc_q)
		|=> cur.st != st_ov_latched)
		else $error("DAC-relative overvoltage used during start-up");
	a_ov_run: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
		(cur.st == st_run && ov_dac_q && enable_in) |=> cur.st == st_ov_latched && !cur.ready)
		else $error("run overvoltage did not drop ready and latch");
	a_ramp_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
		(cur.st == st_ramp && !driver_on_in) |=> cur.dac == $past(cur.dac))
		else $error("ramp advanced while driver-on wire held low");
	a_config_float: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
		cur.st == st_config |-> cur.test_cur && cur.mode_a == `PWM_FLOAT_CODE)
		else $error("PWM not floating with test current during configuration");
endmodule

// >>> verif/gate_driver_model.sv
// Behavioural gate driver that shares the driver-on wire with the sequencer
`timescale 1ns/1ps
module gate_driver_model #(
	parameter int HOLD = 12
) (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic drive_req, // Sequencer driver-on request
	input wire logic supply_low, // Driver supply or bootstrap too low
	output logic wire_level, // Resolved driver-on wire
	output logic holding // Driver still holds the wire low
);
	int hold_cnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= 0;
		end else if (supply_low) begin
			hold_cnt <= HOLD;
		end else if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end
	end
	assign holding = supply_low || (hold_cnt != 0);
	// Open drain: any driver pulling low wins over the sequencer request
	assign wire_level = drive_req && !holding;
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the start-up and fault sequencer
`timescale 1ns/1ps
module testbench;
	localparam int RDIV = 2;
	localparam int OCD = 8;
	localparam int HOLD = 12;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_in = 1'b0;
	logic config_done = 1'b0;
	logic [7:0] target_code = 8'h00;
	logic dynamic_voltage_change = 1'b1;
	logic [1:0] pwm_pulse = 2'h0;
	logic sp_pwm_pulse = 1'b0;
	logic cmp_uv = 1'b0, cmp_ov_dac = 1'b0, cmp_ov_fixed = 1'b0;
	logic cmp_oc = 1'b0, cmp_oc150 = 1'b0, cmp_sp_current_limit_input = 1'b0, drv_low = 1'b0;
	logic driver_wire, holding, test_current_on, driver_on_out, sense_pulse;
	logic regulator_ready, hs_off_all, ls_on_all, sp_latched;
	logic [7:0] dac_code;
	logic [1:0] pwm_mode_a, pwm_mode_b, sp_pwm_mode;
	int num_errors = 0;
	int samples_checked = 0;
	always #25 ref_clk = ~ref_clk;
	vr_softstart_fault_sequencer #(.RAMP_DIV(RDIV), .OC_DELAY(OCD)) uut (.ref_clk(ref_clk),
		.rst_n(rst_n), .enable_in(enable_in), .config_done(config_done),
		.target_code(target_code), .dynamic_voltage_change(dynamic_voltage_change),
		.driver_on_in(driver_wire), .pwm_pulse(pwm_pulse), .sp_pwm_pulse(sp_pwm_pulse),
		.cmp_uv(cmp_uv), .cmp_ov_dac(cmp_ov_dac), .cmp_ov_fixed(cmp_ov_fixed),
		.cmp_oc(cmp_oc), .cmp_oc150(cmp_oc150), .cmp_sp_current_limit_input(cmp_sp_current_limit_input),
		.dac_code(dac_code), .pwm_mode_a(pwm_mode_a), .pwm_mode_b(pwm_mode_b),
		.sp_pwm_mode(sp_pwm_mode), .test_current_on(test_current_on),
		.driver_on_out(driver_on_out), .sense_pulse(sense_pulse),
		.regulator_ready(regulator_ready), .hs_off_all(hs_off_all), .ls_on_all(ls_on_all),
		.sp_latched(sp_latched));
	gate_driver_model #(.HOLD(HOLD)) drv (.ref_clk(ref_clk), .rst_n(rst_n),
		.drive_req(driver_on_out), .supply_low(drv_low), .wire_level(driver_wire),
		.holding(holding));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#2;
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_code(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic watch_of(input int s);
		case (s)
			0: return driver_on_out;
			1: return regulator_ready;
			2: return hs_off_all;
			3: return sp_latched;
			4: return !holding;
			default: return dac_code === 8'h00;
		endcase
	endfunction
	// Bounded wait; a timeout shows up as a failed compare
	task automatic wait_on(input string what, input int s, input logic v, input int lim);
		int k = 0;
		while (watch_of(s) !== v && k < lim) begin
			tick(1);
			k++;
		end
		chk_bit(what, v, watch_of(s));
	endtask
	task automatic power_up();
		rst_n = 1'b0;
		tick(10);
		rst_n = 1'b1;
		enable_in = 1'b1;
		tick(3);
		chk_code("mode a cfg", 8'h00, {6'h0, pwm_mode_a});
		chk_bit("test current", 1'b1, test_current_on);
		chk_bit("drv on cfg", 1'b0, driver_on_out);
		enable_in = 1'b0;
		config_done = 1'b1;
		tick(1);
		config_done = 1'b0;
		tick(2);
		chk_code("mode a cfgd", 8'h02, {6'h0, pwm_mode_a});
		chk_code("sp mode cfgd", 8'h02, {6'h0, sp_pwm_mode});
		chk_bit("test current off", 1'b0, test_current_on);
		chk_bit("drv on off", 1'b0, driver_on_out);
	endtask
	// Reference model: DAC counts up by one every RDIV cycles from zero
	task automatic ramp_up();
		int prev = 0;
		int last = -1;
		int k = 0;
		target_code = 8'(6 + $urandom % 10);
		enable_in = 1'b1;
		wait_on("drv on", 0, 1'b1, 6);
		chk_code("mode a at drv on", 8'h02, {6'h0, pwm_mode_a});
		chk_code("mode b at drv on", 8'h02, {6'h0, pwm_mode_b});
		chk_code("dac start", 8'h00, dac_code);
		while (regulator_ready !== 1'b1 && k < 40 * RDIV) begin
			tick(1);
			k++;
			if (dac_code !== 8'(prev)) begin
				prev++;
				chk_code("dac step", 8'(prev), dac_code);
				chk_bit("sense pulse", dynamic_voltage_change, sense_pulse);
				if (last >= 0) chk_code("step gap", 8'(RDIV), 8'(k - last));
				last = k;
				if (prev == 2) pwm_pulse = 2'b01;
				if (prev == 4) begin
					chk_code("mode a pulsed", 8'h03, {6'h0, pwm_mode_a});
					chk_code("mode b waits", 8'h02, {6'h0, pwm_mode_b});
					pwm_pulse = 2'b11;
					sp_pwm_pulse = 1'b1;
				end
			end
		end
		chk_code("dac at ready", target_code, dac_code);
		chk_code("sp mode ran", 8'h03, {6'h0, sp_pwm_mode});
		pwm_pulse = 2'b00;
		sp_pwm_pulse = 1'b0;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (6000) @(posedge ref_clk);
		num_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(88362));
		power_up();
		ramp_up();
		cmp_uv = 1'b1;
		wait_on("ready uv", 1, 1'b0, 4);
		cmp_uv = 1'b0;
		cmp_sp_current_limit_input = 1'b1;
		wait_on("sp latch", 3, 1'b1, 4);
		cmp_sp_current_limit_input = 1'b0;
		tick(5);
		chk_bit("sp latch held", 1'b1, sp_latched);
		cmp_oc = 1'b1;
		tick(OCD - 4);
		cmp_oc = 1'b0;
		tick(OCD + 4);
		chk_bit("short oc", 1'b1, driver_on_out);
		cmp_oc = 1'b1;
		tick(OCD);
		chk_bit("oc delay", 1'b1, driver_on_out);
		wait_on("oc off", 0, 1'b0, 1);
		cmp_oc = 1'b0;
		tick(20);
		chk_bit("oc held", 1'b0, driver_on_out);
		chk_code("oc mode", 8'h01, {6'h0, pwm_mode_a});
		enable_in = 1'b0;
		tick(3);
		chk_code("disabled mode a", 8'h02, {6'h0, pwm_mode_a});
		chk_code("disabled mode b", 8'h02, {6'h0, pwm_mode_b});
		drv_low = 1'b1;
		tick(1);
		drv_low = 1'b0;
		enable_in = 1'b1;
		tick(6);
		chk_code("dac held", 8'h00, dac_code);
		chk_bit("wire held", 1'b0, driver_wire);
		wait_on("holdoff end", 4, 1'b1, HOLD + 4);
		ramp_up();
		chk_bit("wire high", 1'b1, driver_wire);
		cmp_oc150 = 1'b1;
		wait_on("oc150 off", 0, 1'b0, 3);
		cmp_oc150 = 1'b0;
		enable_in = 1'b0;
		tick(2);
		dynamic_voltage_change = 1'b0;
		ramp_up();
		cmp_ov_dac = 1'b1;
		wait_on("ov hs off", 2, 1'b1, 4);
		chk_bit("ov ls on", 1'b1, ls_on_all);
		chk_bit("ov ready", 1'b0, regulator_ready);
		cmp_ov_dac = 1'b0;
		wait_on("ov dac zero", 5, 1'b1, 40 * RDIV);
		tick(10);
		chk_bit("ov held", 1'b1, hs_off_all);
		power_up();
		target_code = 8'h20;
		enable_in = 1'b1;
		wait_on("drv on2", 0, 1'b1, 6);
		tick(2);
		cmp_ov_dac = 1'b1;
		tick(4);
		chk_bit("start ov dac", 1'b0, hs_off_all);
		cmp_ov_dac = 1'b0;
		cmp_ov_fixed = 1'b1;
		wait_on("start ov fixed", 2, 1'b1, 4);
		cmp_ov_fixed = 1'b0;
		enable_in = 1'b0;
		tick(3);
		chk_bit("ov released", 1'b0, hs_off_all);
		wrap_up();
	end
endmodule
